// ### hdl/cbfs_addr_calc.sv
/*
 * Address arithmetic for the sequencer: next sequential address,
 * relative jump target and store operand address.
 * Assumes pc already points past the byte that held the displacement.
 */
`timescale 1ns/1ps
module cbfs_addr_calc
    import cbfs_pkg::*;
#(
    parameter int AW = CBFS_ADDR_W
) (
    input wire logic [AW-1:0] i_pc,
    input wire logic [7:0] i_operand,
    input wire logic [3:0] i_page,
    output logic [AW-1:0] o_seq_addr,
    output logic [AW-1:0] o_jump_addr,
    output logic [AW-1:0] o_store_addr
);

    // =========================================================
    // Sequential, relative and paged address forms
    logic [AW-1:0] disp_ext;

    // Sign extend so negative displacements walk backwards
    assign disp_ext = {{(AW-8){i_operand[7]}}, i_operand};
    assign o_seq_addr = i_pc + {{(AW-1){1'b0}}, 1'b1};
    // Displacement is taken relative to its own location
    assign o_jump_addr = i_pc - {{(AW-1){1'b0}}, 1'b1} + disp_ext;
    assign o_store_addr = {i_page, i_operand};

endmodule : cbfs_addr_calc

// ### hdl/cbfs_pkg.sv
/*
 * Shared constants for the bus fetch sequencer: bus widths, opcode
 * encodings, reset values and the operand page used by store.
 * Assumes a single clock domain and an external shared memory/I/O bus.
 */
package cbfs_pkg;

    // =========================================================
    // Bus geometry
    localparam int CBFS_ADDR_W = 12;
    localparam int CBFS_DATA_W = 8;
    localparam int CBFS_CTRL_LINES = 3;

    // =========================================================
    // Opcodes handled by the sequencer
    localparam logic [7:0] CBFS_NOP_OP = 8'h08;
    localparam logic [7:0] CBFS_LOAD_IMMEDIATE_OP = 8'hc4;
    localparam logic [7:0] CBFS_STORE_OP = 8'hc8;
    localparam logic [7:0] CBFS_SWAP_ACC_EXT_OP = 8'h01;
    localparam logic [7:0] CBFS_RELATIVE_JUMP_OP = 8'h90;

    // =========================================================
    // Reset values
    localparam logic [11:0] CBFS_RESET_PC = 12'h000;
    localparam logic [7:0] CBFS_RESET_BYTE = 8'h00;

    // Upper address bits of the region that store operands land in
    localparam logic [3:0] CBFS_STORE_PAGE = 4'h9;

    // =========================================================
    // Sequencer states, Gray along idle-address-strobe-done
    typedef enum logic [1:0] {
        CBFS_S_IDLE = 2'b00,
        CBFS_S_ADDR = 2'b01,
        CBFS_S_STRB = 2'b11,
        CBFS_S_DONE = 2'b10
    } cbfs_state_t;

    // Purpose of the bus cycle in progress
    typedef enum logic [1:0] {
        CBFS_K_FETCH = 2'b00,
        CBFS_K_OPER = 2'b01,
        CBFS_K_WRITE = 2'b11
    } cbfs_kind_t;

endpackage : cbfs_pkg

// ### hdl/cbfs_sequencer.sv
/*
 * Fetch and execute sequencer of a small 8-bit processor. Drives the
 * address bus, the data bus (three-signal form) and three active-low
 * control strobes. Each bus cycle is three clocks: address, strobe, done.
 * Assumes memory answers reads within the strobe clock and that I/O
 * decodes its own region and latches data on the write strobe.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Address bus is 12 lines, data bus 8 lines shared by memory and I/O.
// - Control bus is three lines: address, read and write strobes.
// - Under reset all registers but the strobes are zero and the bus stays idle.
// - After reset the first opcode is fetched from address zero.
// - Every bus cycle presents the address and asserts the address strobe.
// - On reads memory drives data; the sequencer captures it and pulses read.
// - A no-op changes no register and then fetches the next opcode.
// - Load immediate reads the next byte into the accumulator.
// - Store first fetches an addressing byte, forming an unrelated address.
// - Store then outputs that address, drives the accumulator, pulses write.
// - After an operand access fetching resumes after the instruction's last byte.
// - Swap exchanges accumulator and extension in one step using old values.
// - Operand-free single-byte instructions go straight to the next fetch.
// - Jump fetches a signed displacement and continues at the derived target.
// - Instructions take one, two or three address cycles.
module cbfs_sequencer
    import cbfs_pkg::*;
#(
    parameter int AW = CBFS_ADDR_W,
    parameter int DW = CBFS_DATA_W,
    parameter logic [3:0] STORE_PAGE = CBFS_STORE_PAGE
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    output logic [AW-1:0] o_addr,
    input wire logic [DW-1:0] i_data,
    output logic [DW-1:0] o_data,
    output logic o_data_oe,
    output logic o_address_valid_strobe_n,
    output logic o_read_data_strobe_n,
    output logic o_write_data_strobe_n
);

    // =========================================================
    // State and datapath registers
    cbfs_state_t state_r, state_nxt;
    cbfs_kind_t kind_r, kind_nxt;
    logic [AW-1:0] pc_r, pc_nxt;
    logic [DW-1:0] acc_r, acc_nxt;
    logic [DW-1:0] ext_r, ext_nxt;
    logic [DW-1:0] ir_r, ir_nxt;
    logic [DW-1:0] opnd_r, opnd_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [DW-1:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic ads_n_r, ads_n_nxt;
    logic rd_n_r, rd_n_nxt;
    logic wr_n_r, wr_n_nxt;

    logic [AW-1:0] seq_addr;
    logic [AW-1:0] jump_addr;
    logic [AW-1:0] store_addr;
    logic needs_operand;

    // =========================================================
    // Address arithmetic
    cbfs_addr_calc #(
        .AW(AW)
    ) u_addr_calc (
        .i_pc(pc_r),
        .i_operand(opnd_r),
        .i_page(STORE_PAGE),
        .o_seq_addr(seq_addr),
        .o_jump_addr(jump_addr),
        .o_store_addr(store_addr)
    );

    // Opcodes that carry a second byte
    assign needs_operand = (ir_r == CBFS_LOAD_IMMEDIATE_OP) ||
                           (ir_r == CBFS_STORE_OP) ||
                           (ir_r == CBFS_RELATIVE_JUMP_OP);

    // =========================================================
    // Next-state and datapath computation
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        pc_nxt = pc_r;
        acc_nxt = acc_r;
        ext_nxt = ext_r;
        ir_nxt = ir_r;
        opnd_nxt = opnd_r;
        addr_nxt = addr_r;
        case (state_r)
            CBFS_S_IDLE: begin
                // First bus cycle after reset reads address zero
                state_nxt = CBFS_S_ADDR;
                kind_nxt = CBFS_K_FETCH;
                addr_nxt = CBFS_RESET_PC;
                pc_nxt = CBFS_RESET_PC + {{(AW-1){1'b0}}, 1'b1};
            end
            CBFS_S_ADDR: begin
                state_nxt = CBFS_S_STRB; // Address settled, now strobe
            end
            CBFS_S_STRB: begin
                // Read data sampled at the end of the strobe clock
                state_nxt = CBFS_S_DONE;
                if (kind_r == CBFS_K_FETCH) begin
                    ir_nxt = i_data;
                end else if (kind_r == CBFS_K_OPER) begin
                    opnd_nxt = i_data;
                end
            end
            CBFS_S_DONE: begin
                state_nxt = CBFS_S_ADDR;
                // Default: next opcode at the sequential address
                kind_nxt = CBFS_K_FETCH;
                addr_nxt = pc_r;
                pc_nxt = seq_addr;
                if (kind_r == CBFS_K_FETCH) begin
                    if (needs_operand) begin
                        // Second address cycle for the operand byte
                        kind_nxt = CBFS_K_OPER;
                    end else if (ir_r == CBFS_SWAP_ACC_EXT_OP) begin
                        // Both take the other's old value
                        acc_nxt = ext_r;
                        ext_nxt = acc_r;
                    end
                    // No-op and unknown opcodes change nothing
                end else if (kind_r == CBFS_K_OPER) begin
                    if (ir_r == CBFS_LOAD_IMMEDIATE_OP) begin
                        acc_nxt = opnd_r;
                    end else if (ir_r == CBFS_STORE_OP) begin
                        // Third cycle at the formed address, pc is kept
                        kind_nxt = CBFS_K_WRITE;
                        addr_nxt = store_addr;
                        pc_nxt = pc_r;
                    end else begin
                        // Relative jump continues at the target
                        addr_nxt = jump_addr;
                        pc_nxt = jump_addr + {{(AW-1){1'b0}}, 1'b1};
                    end
                end
                // After a write fetching resumes at pc
            end
            default: begin
                state_nxt = CBFS_S_IDLE;
            end
        endcase
    end

    // =========================================================
    // Bus pin values follow the next state so pins come from flops
    always_comb begin
        ads_n_nxt = 1'b1;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        doe_nxt = 1'b0;
        dout_nxt = dout_r;
        if (state_nxt == CBFS_S_ADDR) begin
            ads_n_nxt = 1'b0;
        end
        if (state_nxt == CBFS_S_STRB) begin
            // Exactly one of read or write per cycle
            if (kind_nxt == CBFS_K_WRITE) begin
                wr_n_nxt = 1'b0;
            end else begin
                rd_n_nxt = 1'b0;
            end
        end
        // Data driven across the whole write cycle for setup and hold
        if (kind_nxt == CBFS_K_WRITE && state_nxt != CBFS_S_IDLE) begin
            doe_nxt = 1'b1;
            dout_nxt = acc_r;
        end
    end

    // =========================================================
    // Registers; reset clears everything and parks the bus
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= CBFS_S_IDLE;
            kind_r <= CBFS_K_FETCH;
            pc_r <= CBFS_RESET_PC;
            acc_r <= CBFS_RESET_BYTE;
            ext_r <= CBFS_RESET_BYTE;
            ir_r <= CBFS_RESET_BYTE;
            opnd_r <= CBFS_RESET_BYTE;
            addr_r <= CBFS_RESET_PC;
            dout_r <= CBFS_RESET_BYTE;
            doe_r <= 1'b0;
            ads_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            pc_r <= pc_nxt;
            acc_r <= acc_nxt;
            ext_r <= ext_nxt;
            ir_r <= ir_nxt;
            opnd_r <= opnd_nxt;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            ads_n_r <= ads_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
        end
    end

    // =========================================================
    // Outputs straight from flops
    assign o_addr = addr_r;
    assign o_data = dout_r;
    assign o_data_oe = doe_r;
    assign o_address_valid_strobe_n = ads_n_r;
    assign o_read_data_strobe_n = rd_n_r;
    assign o_write_data_strobe_n = wr_n_r;

    // =========================================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    AST_IDLE_QUIET: assert property (
        (state_r == CBFS_S_IDLE) |-> (ads_n_r && rd_n_r && wr_n_r && !doe_r))
        else $error("bus active while idle");

    AST_FIRST_FETCH: assert property (
        (state_r == CBFS_S_IDLE) |=> (!ads_n_r && addr_r == CBFS_RESET_PC))
        else $error("first fetch not at zero");

    AST_ADS_THEN_STRB: assert property (
        !ads_n_r |=> (ads_n_r && (!rd_n_r || !wr_n_r) && $stable(addr_r))
                     ##1 (rd_n_r && wr_n_r && $stable(addr_r)))
        else $error("bus cycle shape wrong");

    AST_ONE_STROBE: assert property (
        !(!rd_n_r && !wr_n_r) && !(!ads_n_r && (!rd_n_r || !wr_n_r)))
        else $error("strobes overlap");

    AST_WRITE_DATA: assert property (
        !wr_n_r |-> (doe_r && dout_r == acc_r))
        else $error("write without accumulator data");

    AST_LOAD_IMM: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_OPER &&
         ir_r == CBFS_LOAD_IMMEDIATE_OP) |=> (acc_r == $past(opnd_r)))
        else $error("load immediate lost");

    AST_SWAP: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_FETCH &&
         ir_r == CBFS_SWAP_ACC_EXT_OP)
        |=> (acc_r == $past(ext_r) && ext_r == $past(acc_r)))
        else $error("swap wrong");

    AST_NOP_NEXT: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_FETCH &&
         ir_r == CBFS_NOP_OP)
        |=> ($stable(acc_r) && $stable(ext_r) && !ads_n_r &&
             kind_r == CBFS_K_FETCH && addr_r == $past(pc_r)))
        else $error("no-op not sequential");

    AST_JUMP: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_OPER &&
         ir_r == CBFS_RELATIVE_JUMP_OP) |=> (addr_r == $past(jump_addr)))
        else $error("jump target wrong");

    AST_STORE: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_OPER &&
         ir_r == CBFS_STORE_OP)
        |=> (addr_r == {STORE_PAGE, $past(opnd_r)}) ##1 !wr_n_r)
        else $error("store address wrong");

    AST_RESUME: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_WRITE)
        |=> (kind_r == CBFS_K_FETCH && addr_r == $past(pc_r)))
        else $error("no resume after store");

    AST_FETCH_CAPTURE: assert property (
        (!rd_n_r && kind_r == CBFS_K_FETCH) |=> (ir_r == $past(i_data)))
        else $error("opcode not captured");

    AST_NO_CONTENTION: assert property (
        !rd_n_r |-> !doe_r)
        else $error("data driven during read");

    AST_SINGLE_BYTE_NEXT: assert property (
        (state_r == CBFS_S_DONE && kind_r == CBFS_K_FETCH &&
         ir_r == CBFS_SWAP_ACC_EXT_OP)
        |=> (!ads_n_r && kind_r == CBFS_K_FETCH && addr_r == $past(pc_r)))
        else $error("single-byte opcode fetched an operand");

    COV_ONE_CYCLE: cover property (
        state_r == CBFS_S_DONE && kind_r == CBFS_K_FETCH && !needs_operand);
    COV_LOAD: cover property (
        state_r == CBFS_S_DONE && kind_r == CBFS_K_OPER &&
        ir_r == CBFS_LOAD_IMMEDIATE_OP);
    COV_STORE: cover property (!wr_n_r);
    COV_JUMP_BACK: cover property (
        state_r == CBFS_S_DONE && kind_r == CBFS_K_OPER &&
        ir_r == CBFS_RELATIVE_JUMP_OP && opnd_r[7]);

endmodule : cbfs_sequencer

// ### tb/cbfs_mem_model.sv
/* Memory and I/O partner for the fetch sequencer bench.
   Assumes the device pins are wired straight in; single clock. */
`timescale 1ns/1ps
module cbfs_mem_model (
    input wire logic i_sys_clk,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_dev_data,
    input wire logic i_dev_oe,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    output logic [7:0] o_bus
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_r = 8'h00;
    logic [11:0] io_addr_r = 12'h000;
    logic [7:0] io_data_r = 8'h00;

    // ==========================================================
    // Bus level
    // Released bus flips every clock so a stale byte is never seen
    always_comb begin
        if (i_dev_oe) begin
            o_bus = i_dev_data;
        end else if (!i_rd_n) begin
            o_bus = mem[i_addr];
        end else begin
            o_bus = ~last_r;
        end
    end

    // I/O port latches on the write strobe in its own region only
    always @(posedge i_sys_clk) begin
        last_r <= o_bus;
        if (!i_wr_n && i_addr[11:8] == 4'h9) begin
            io_addr_r <= i_addr;
            io_data_r <= o_bus;
        end
    end
endmodule : cbfs_mem_model

// ### tb/cpu_bus_fetch_sequencer_tb_top.sv
/* Self-checking bench for the fetch sequencer.
   Assumes the sequencer and the memory partner model sit on one clock. */
`timescale 1ns/1ps
module cpu_bus_fetch_sequencer_tb_top;
    import cbfs_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [11:0] addr;
    logic [7:0] bus;
    logic [7:0] dout;
    logic oe, ads_n, rd_n, wr_n;
    int bad_count = 0;
    int num_checks = 0;
    int clk_n = 0;
    int last_ads = -1;

    cbfs_sequencer i_cbfs_sequencer (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .o_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe(oe),
        .o_address_valid_strobe_n(ads_n), .o_read_data_strobe_n(rd_n),
        .o_write_data_strobe_n(wr_n));
    cbfs_mem_model i_cbfs_mem_model (.i_sys_clk(i_sys_clk), .i_addr(addr),
        .i_dev_data(dout), .i_dev_oe(oe), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_bus(bus));

    // ==========================================================
    // Clock and cycle count
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) clk_n <= clk_n + 1;

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // One whole bus cycle; returns mid strobe clock (write: mid done clock)
    task automatic bus_cycle(input logic [11:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        while (ads_n !== 1'b0 && n < 8) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(16'(n < 8), 16'h1, "address strobe");
        if (last_ads >= 0) check(16'(clk_n - last_ads), 16'h3, "spacing");
        last_ads = clk_n;
        check(16'(addr), 16'(a), "address");
        check(16'({rd_n, wr_n}), 16'h3, "strobes in address clock");
        @(negedge i_sys_clk);
        check(16'(addr), 16'(a), "address hold");
        check(16'({ads_n, rd_n, wr_n, oe}), wr ? 16'hd : 16'ha, "strobes");
        if (wr) begin
            check(16'(dout), 16'(d), "write data");
            @(negedge i_sys_clk);
            check(16'(i_cbfs_mem_model.io_addr_r), 16'(a), "io address");
            check(16'(i_cbfs_mem_model.io_data_r), 16'(d), "io data");
        end
    endtask : bus_cycle

    // Reset is already low on entry; held three clocks then released
    task automatic do_reset();
        repeat (3) @(negedge i_sys_clk);
        check({addr, oe, ads_n, rd_n, wr_n}, {12'h000, 4'b0111}, "in reset");
        i_arst_n = 1'b1;
        check(16'(ads_n), 16'h1, "idle at release");
        // First edge after release already asserts (drives low) the address strobe
        @(negedge i_sys_clk);
        check(16'(ads_n), 16'h0, "strobe one clock after release");
        last_ads = -1;
        bus_cycle(CBFS_RESET_PC, 1'b0, 8'h00);
    endtask : do_reset

    // ==========================================================
    // Scenarios
    // Nop, load, store, swap, store, jump back to zero, twice round
    task automatic test_program_loop();
        for (int it = 0; it < 2; it++) begin
            if (it > 0) bus_cycle(12'h000, 1'b0, 8'h00);
            bus_cycle(12'h001, 1'b0, 8'h00);
            bus_cycle(12'h002, 1'b0, 8'h00);
            bus_cycle(12'h003, 1'b0, 8'h00);
            bus_cycle(12'h004, 1'b0, 8'h00);
            bus_cycle(12'h921, 1'b1, 8'h5a);
            bus_cycle(12'h005, 1'b0, 8'h00);
            bus_cycle(12'h006, 1'b0, 8'h00);
            bus_cycle(12'h007, 1'b0, 8'h00);
            bus_cycle(12'h922, 1'b1, it == 0 ? 8'h00 : 8'h5a);
            bus_cycle(12'h008, 1'b0, 8'h00);
            bus_cycle(12'h009, 1'b0, 8'h00);
        end
    endtask : test_program_loop

    // Reset lands in the middle of a write strobe
    task automatic test_reset_mid_store();
        bus_cycle(12'h000, 1'b0, 8'h00);
        for (int k = 1; k < 5; k++) bus_cycle(12'(k), 1'b0, 8'h00);
        repeat (3) @(negedge i_sys_clk);
        check(16'(wr_n), 16'h0, "write strobe before reset");
        i_arst_n = 1'b0;
        #1;
        check(16'({oe, ads_n, rd_n, wr_n}), 16'h7, "async reset");
        i_cbfs_mem_model.mem[0] = CBFS_RELATIVE_JUMP_OP;
        i_cbfs_mem_model.mem[1] = 8'h80;
        do_reset();
    endtask : test_reset_mid_store

    // Backward jump wraps below zero; store then shows a cleared accumulator
    task automatic test_jump_wrap();
        bus_cycle(12'h001, 1'b0, 8'h00);
        bus_cycle(12'hf81, 1'b0, 8'h00);
        bus_cycle(12'hf82, 1'b0, 8'h00);
        bus_cycle(12'hf83, 1'b0, 8'h00);
        bus_cycle(12'h930, 1'b1, 8'h00);
        bus_cycle(12'hf84, 1'b0, 8'h00);
    endtask : test_jump_wrap

    // ==========================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 4096; i++) i_cbfs_mem_model.mem[i] = CBFS_NOP_OP;
        i_cbfs_mem_model.mem[1] = CBFS_LOAD_IMMEDIATE_OP;
        i_cbfs_mem_model.mem[2] = 8'h5a;
        i_cbfs_mem_model.mem[3] = CBFS_STORE_OP;
        i_cbfs_mem_model.mem[4] = 8'h21;
        i_cbfs_mem_model.mem[5] = CBFS_SWAP_ACC_EXT_OP;
        i_cbfs_mem_model.mem[6] = CBFS_STORE_OP;
        i_cbfs_mem_model.mem[7] = 8'h22;
        i_cbfs_mem_model.mem[8] = CBFS_RELATIVE_JUMP_OP;
        i_cbfs_mem_model.mem[9] = 8'hf7;
        i_cbfs_mem_model.mem[12'hf82] = CBFS_STORE_OP;
        i_cbfs_mem_model.mem[12'hf83] = 8'h30;
        do_reset();
        test_program_loop();
        test_reset_mid_store();
        test_jump_wrap();
        results();
    end

    // Whole run is about 115 clocks; this span is far beyond it
    initial begin
        #200000;
        bad_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        results();
    end
endmodule : cpu_bus_fetch_sequencer_tb_top
